// ==== core/xst_regs.svh ====
`ifndef XST_REGS_SVH
`define XST_REGS_SVH

// ----------------------------------------------------------------
// Engine dimensions
// ----------------------------------------------------------------
`define XST_NUM_CH       7
`define XST_FN_NUM       9

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define XST_OFS_CFG      8'hc9
`define XST_OFS_BAL      8'hca
`define XST_OFS_BAH      8'hcb
`define XST_OFS_AOL      8'hcc
`define XST_OFS_AOH      8'hcd
`define XST_OFS_SZL      8'hce
`define XST_OFS_SZH      8'hcf
`define XST_OFS_SEL      8'hd1
`define XST_OFS_EN       8'hd2
`define XST_OFS_FULL     8'hd3
`define XST_OFS_HALF     8'hd4
`define XST_OFS_BUSY     8'hd5
`define XST_OFS_MD       8'hd6

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define XST_CFG_FN_MSB   3
`define XST_CFG_FN_LSB   0
`define XST_MD_CONT_BIT  0
`define XST_RST_BYTE     8'h00
`define XST_RST_WORD     16'h0000
`define XST_ENC_BYTES    16'h0003

// ----------------------------------------------------------------
// Transfer function codes
// ----------------------------------------------------------------
`define XST_FN_RAM_ENC   4'h0
`define XST_FN_ENC_RAM   4'h1
`define XST_FN_RAM_CRC   4'h2
`define XST_FN_RAM_SPI   4'h3
`define XST_FN_SPI_RAM   4'h4
`define XST_FN_RAM_KEY   4'h5
`define XST_FN_RAM_BLK   4'h6
`define XST_FN_RAM_XOR   4'h7
`define XST_FN_AES_RAM   4'h8

`endif

// ==== core/xst_pkg.sv ====
package xst_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {st_idle, st_fetch, st_capture, st_store} xst_state_t;
  typedef logic [3:0] xst_func_t;

endpackage : xst_pkg

// ==== core/xst_arb_if.sv ====
`timescale 1ns/1ps

interface xst_arb_if #(parameter int N = 7);
  logic [N-1:0]         req;
  logic                 grant_valid;
  logic [$clog2(N)-1:0] grant_idx;

  modport src (output req, input grant_valid, input grant_idx);
  modport arb (input req, output grant_valid, output grant_idx);
endinterface : xst_arb_if

// ==== core/xst_arb.sv ====
`timescale 1ns/1ps

module xst_arb import xst_pkg::*; #(
  parameter int N = 7
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Request and grant
  xst_arb_if.arb   bus
);

  // ----------------------------------------------------------------
  // Fixed priority, lowest channel first
  // ----------------------------------------------------------------
  // A busy low channel can starve higher ones; kept simple on purpose
  always_comb begin
    bus.grant_valid = 1'b0;
    bus.grant_idx   = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (bus.req[i]) begin
        bus.grant_valid = 1'b1;
        bus.grant_idx   = ($clog2(N))'(i);
      end
    end
  end

  chk_grant_legal: assert property (@(posedge sys_clk) disable iff (rst)
    bus.grant_valid |-> bus.req[bus.grant_idx])
    else $error("grant to a channel without request");

  chk_grant_any: assert property (@(posedge sys_clk) disable iff (rst)
    (bus.req != '0) |-> (bus.grant_valid && ((bus.req & ((N'(1) << bus.grant_idx) - N'(1))) == '0)))
    else $error("pending request not granted to lowest channel");

endmodule : xst_arb

// ==== core/xst_engine.sv ====
`timescale 1ns/1ps
`include "xst_regs.svh"

// Summary of operation
// - Seven independent channels, shared registers, one engine
// - Each channel owns function, mode, address registers
// - Moves bytes between RAM and peripherals autonomously
// - Each channel runs one of nine functions
// - Half flag set at half length
// - Full flag set at full length
// - Base address reaches selected channel only
// - Offset high and low reach selected channel
// - Size high and low reach selected channel
// - Mode register reaches selected channel
module xst_engine import xst_pkg::*; #(
  parameter int CH_NUM = `XST_NUM_CH,
  parameter int FN_NUM = `XST_FN_NUM
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Special function register port
  input  wire logic [7:0]        sfr_addr,
  input  wire logic              sfr_wr,
  input  wire logic              sfr_rd,
  input  wire logic [7:0]        sfr_wdata,
  output logic      [7:0]        sfr_rdata,
  // Data RAM port
  output logic      [15:0]       ram_addr,
  output logic                   ram_rd,
  output logic                   ram_wr,
  output logic      [7:0]        ram_wdata,
  input  wire logic [7:0]        ram_rdata,
  // Peripheral data registers
  input  wire logic [FN_NUM-1:0] periph_ready,
  output logic      [3:0]        periph_func,
  output logic      [1:0]        periph_lane,
  output logic                   periph_rd,
  output logic                   periph_wr,
  output logic      [7:0]        periph_wdata,
  input  wire logic [7:0]        periph_rdata,
  // Event flags
  output logic      [CH_NUM-1:0] half_flags,
  output logic      [CH_NUM-1:0] full_flags
);

  localparam int IW = $clog2(CH_NUM);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic func_to_ram(input xst_func_t f);
    func_to_ram = (f == `XST_FN_ENC_RAM) || (f == `XST_FN_SPI_RAM) || (f == `XST_FN_AES_RAM);
  endfunction : func_to_ram

  function automatic logic func_legal(input xst_func_t f);
    func_legal = (f <= `XST_FN_AES_RAM);
  endfunction : func_legal

  function automatic logic [1:0] lane_of(input xst_func_t f, input logic [15:0] off);
    logic [15:0] rem;
    rem = off % `XST_ENC_BYTES;
    lane_of = ((f == `XST_FN_RAM_ENC) || (f == `XST_FN_ENC_RAM)) ? rem[1:0] : 2'h0;
  endfunction : lane_of

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]       cfg  [CH_NUM];
  logic [7:0]       md   [CH_NUM];
  logic [15:0]      base [CH_NUM];
  logic [15:0]      offs [CH_NUM];
  logic [15:0]      size [CH_NUM];
  logic [7:0]       sel;
  logic [CH_NUM-1:0] en;
  logic [CH_NUM-1:0] busy;
  logic [CH_NUM-1:0] req;
  logic [CH_NUM-1:0] half_set;
  logic [CH_NUM-1:0] full_set;
  logic [CH_NUM-1:0] en_clr;
  xst_state_t       state;
  logic [IW-1:0]    act_ch;
  logic [7:0]       xfer_data;
  logic [7:0]       rd_mux;
  logic [15:0]      next_off;
  logic             sel_ok;
  logic [IW-1:0]    sel_idx;
  logic             store;
  logic             to_ram;
  logic             at_end;
  logic             at_half;
  logic             cont;

  xst_arb_if #(.N(CH_NUM)) arb_bus ();

  assign sel_ok  = (sel < 8'(CH_NUM));
  assign sel_idx = sel[IW-1:0];
  assign store   = (state == st_store);
  assign to_ram  = func_to_ram(periph_func);
  assign next_off = offs[act_ch] + 16'h0001;
  assign at_end  = (next_off == size[act_ch]);
  assign at_half = (next_off == {1'b0, size[act_ch][15:1]});
  assign cont    = md[act_ch][`XST_MD_CONT_BIT];

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = sfr_wr && (sfr_addr == a);
  endfunction : wr_hit

  function automatic logic chan_wr(input logic [7:0] a);
    chan_wr = sfr_wr && (sfr_addr == a) && sel_ok;
  endfunction : chan_wr

  // ----------------------------------------------------------------
  // Channel setup registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < CH_NUM; i++) begin
        cfg[i]  <= `XST_RST_BYTE;
        md[i]   <= `XST_RST_BYTE;
        base[i] <= `XST_RST_WORD;
        size[i] <= `XST_RST_WORD;
      end
    end else begin
      if (chan_wr(`XST_OFS_CFG)) cfg[sel_idx] <= sfr_wdata;
      if (chan_wr(`XST_OFS_MD))  md[sel_idx]  <= sfr_wdata;
      if (chan_wr(`XST_OFS_BAL)) base[sel_idx][7:0]  <= sfr_wdata;
      if (chan_wr(`XST_OFS_BAH)) base[sel_idx][15:8] <= sfr_wdata;
      if (chan_wr(`XST_OFS_SZL)) size[sel_idx][7:0]  <= sfr_wdata;
      if (chan_wr(`XST_OFS_SZH)) size[sel_idx][15:8] <= sfr_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sel <= `XST_RST_BYTE;
    end else if (wr_hit(`XST_OFS_SEL)) begin
      sel <= sfr_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Offsets: software write takes precedence over the engine step
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < CH_NUM; i++) begin
        offs[i] <= `XST_RST_WORD;
      end
    end else begin
      for (int i = 0; i < CH_NUM; i++) begin
        if (chan_wr(`XST_OFS_AOL) && (sel_idx == IW'(i))) begin
          offs[i][7:0] <= sfr_wdata;
        end else if (chan_wr(`XST_OFS_AOH) && (sel_idx == IW'(i))) begin
          offs[i][15:8] <= sfr_wdata;
        end else if (store && (act_ch == IW'(i))) begin
          offs[i] <= (at_end && cont) ? `XST_RST_WORD : next_off;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Enables and completion flags
  // ----------------------------------------------------------------
  always_comb begin
    half_set = '0;
    full_set = '0;
    en_clr   = '0;
    if (store) begin
      half_set[act_ch] = at_half;
      full_set[act_ch] = at_end;
      en_clr[act_ch]   = at_end && !cont;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      en <= '0;
    end else if (wr_hit(`XST_OFS_EN)) begin
      en <= sfr_wdata[CH_NUM-1:0];
    end else begin
      en <= en & ~en_clr;
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      half_flags <= '0;
      full_flags <= '0;
    end else begin
      half_flags <= (wr_hit(`XST_OFS_HALF) ? sfr_wdata[CH_NUM-1:0] : half_flags) | half_set;
      full_flags <= (wr_hit(`XST_OFS_FULL) ? sfr_wdata[CH_NUM-1:0] : full_flags) | full_set;
    end
  end

  // ----------------------------------------------------------------
  // Busy and requests
  // ----------------------------------------------------------------
  // Illegal function codes never request, so they cannot index past the ready lines
  always_comb begin
    busy = '0;
    req  = '0;
    for (int i = 0; i < CH_NUM; i++) begin
      busy[i] = en[i] && (offs[i] != size[i]) && func_legal(cfg[i][`XST_CFG_FN_MSB:`XST_CFG_FN_LSB]);
      req[i]  = busy[i] && periph_ready[cfg[i][`XST_CFG_FN_MSB:`XST_CFG_FN_LSB]];
    end
  end

  assign arb_bus.req = req;

  xst_arb #(.N(CH_NUM)) u_arb (
    .sys_clk (sys_clk),
    .rst     (rst),
    .bus     (arb_bus.arb)
  );

  // ----------------------------------------------------------------
  // Transfer sequencer: four cycles per byte
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= st_idle;
    end else begin
      unique case (state)
        st_idle:    if (arb_bus.grant_valid) state <= st_fetch;
        st_fetch:   state <= st_capture;
        st_capture: state <= st_store;
        st_store:   state <= st_idle;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      act_ch      <= '0;
      periph_func <= `XST_FN_RAM_ENC;
      periph_lane <= 2'h0;
      ram_addr    <= `XST_RST_WORD;
    end else if (state == st_idle && arb_bus.grant_valid) begin
      act_ch      <= arb_bus.grant_idx;
      periph_func <= cfg[arb_bus.grant_idx][`XST_CFG_FN_MSB:`XST_CFG_FN_LSB];
      periph_lane <= lane_of(cfg[arb_bus.grant_idx][`XST_CFG_FN_MSB:`XST_CFG_FN_LSB],
                             offs[arb_bus.grant_idx]);
      ram_addr    <= base[arb_bus.grant_idx] + offs[arb_bus.grant_idx];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      xfer_data <= `XST_RST_BYTE;
    end else if (state == st_capture) begin
      xfer_data <= to_ram ? periph_rdata : ram_rdata;
    end
  end

  assign ram_wdata    = xfer_data;
  assign periph_wdata = xfer_data;
  assign ram_rd       = (state == st_fetch) && !to_ram;
  assign periph_rd    = (state == st_fetch) && to_ram;
  assign ram_wr       = store && to_ram;
  assign periph_wr    = store && !to_ram;

  // ----------------------------------------------------------------
  // Register read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = `XST_RST_BYTE;
    unique case (sfr_addr)
      `XST_OFS_CFG:  rd_mux = sel_ok ? cfg[sel_idx] : `XST_RST_BYTE;
      `XST_OFS_MD:   rd_mux = sel_ok ? md[sel_idx] : `XST_RST_BYTE;
      `XST_OFS_BAL:  rd_mux = sel_ok ? base[sel_idx][7:0] : `XST_RST_BYTE;
      `XST_OFS_BAH:  rd_mux = sel_ok ? base[sel_idx][15:8] : `XST_RST_BYTE;
      `XST_OFS_AOL:  rd_mux = sel_ok ? offs[sel_idx][7:0] : `XST_RST_BYTE;
      `XST_OFS_AOH:  rd_mux = sel_ok ? offs[sel_idx][15:8] : `XST_RST_BYTE;
      `XST_OFS_SZL:  rd_mux = sel_ok ? size[sel_idx][7:0] : `XST_RST_BYTE;
      `XST_OFS_SZH:  rd_mux = sel_ok ? size[sel_idx][15:8] : `XST_RST_BYTE;
      `XST_OFS_SEL:  rd_mux = sel;
      `XST_OFS_EN:   rd_mux = 8'(en);
      `XST_OFS_FULL: rd_mux = 8'(full_flags);
      `XST_OFS_HALF: rd_mux = 8'(half_flags);
      `XST_OFS_BUSY: rd_mux = 8'(busy);
      default:       rd_mux = `XST_RST_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sfr_rdata <= `XST_RST_BYTE;
    end else if (sfr_rd) begin
      sfr_rdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_fetch_after_grant: assert property (@(posedge sys_clk) disable iff (rst)
    (state == st_idle && arb_bus.grant_valid) |=> (state == st_fetch) ##2 (state == st_store))
    else $error("byte sequence broken after grant");

  chk_single_strobe: assert property (@(posedge sys_clk) disable iff (rst)
    $onehot0({ram_rd, ram_wr, periph_rd, periph_wr}))
    else $error("more than one data strobe active");

  chk_dir_pairing: assert property (@(posedge sys_clk) disable iff (rst)
    ram_rd |-> ##2 periph_wr)
    else $error("RAM read not followed by peripheral write");

  chk_half_flag: assert property (@(posedge sys_clk) disable iff (rst)
    (store && at_half) |=> half_flags[$past(act_ch)])
    else $error("half flag missing at half length");

  chk_full_flag: assert property (@(posedge sys_clk) disable iff (rst)
    (store && at_end) |=> full_flags[$past(act_ch)])
    else $error("full flag missing at full length");

  chk_stop_at_size: assert property (@(posedge sys_clk) disable iff (rst)
    (store && at_end && !cont && !wr_hit(`XST_OFS_EN)) |=> !en[$past(act_ch)])
    else $error("channel still enabled after last byte");

  chk_busy_needs_en: assert property (@(posedge sys_clk) disable iff (rst)
    (busy & ~en) == '0)
    else $error("busy without enable");

  chk_addr_base_off: assert property (@(posedge sys_clk) disable iff (rst)
    (state == st_fetch && !$past(sfr_wr)) |-> (ram_addr == base[act_ch] + offs[act_ch]))
    else $error("RAM address differs from base plus offset");

  chk_offset_step: assert property (@(posedge sys_clk) disable iff (rst)
    (store && !sfr_wr && !(at_end && cont)) |=> (offs[$past(act_ch)] == $past(next_off)))
    else $error("offset did not advance by one");

  chk_sel_read: assert property (@(posedge sys_clk) disable iff (rst)
    (sfr_rd && sfr_addr == `XST_OFS_BAL && sel_ok) |=> (sfr_rdata == $past(base[sel_idx][7:0])))
    else $error("base low read not from selected channel");

endmodule : xst_engine

// ==== testbench/xst_partner.sv ====
`timescale 1ns/1ps

module xst_partner (
  // Clock
  input  wire logic        sys_clk,
  // Data RAM side
  input  wire logic [15:0] ram_addr,
  input  wire logic        ram_rd,
  input  wire logic        ram_wr,
  input  wire logic [7:0]  ram_wdata,
  output logic      [7:0]  ram_rdata,
  // Peripheral data registers
  input  wire logic [3:0]  periph_func,
  input  wire logic [1:0]  periph_lane,
  input  wire logic        periph_rd,
  input  wire logic        periph_wr,
  input  wire logic [7:0]  periph_wdata,
  output logic      [7:0]  periph_rdata,
  output logic      [7:0]  rd_count
);
  logic [7:0]  mem [0:65535];
  logic [13:0] log_q [$];
  logic [5:0]  rd_q  [$];

  initial begin
    ram_rdata    = 8'h00;
    periph_rdata = 8'h00;
    rd_count     = 8'h00;
  end

  // ----------------------------------------------------------------
  // Data RAM
  // ----------------------------------------------------------------
  // Read data lives one cycle only; it toggles after so stale bytes never pass
  always @(posedge sys_clk) begin
    ram_rdata <= ram_rd ? mem[ram_addr] : ~ram_rdata;
    if (ram_wr) mem[ram_addr] <= ram_wdata;
  end

  // ----------------------------------------------------------------
  // Peripheral registers
  // ----------------------------------------------------------------
  // Peripheral enabling is the bench's job, seen by the engine only as periph_ready
  always @(posedge sys_clk) begin
    if (periph_rd) begin
      periph_rdata <= 8'h5a ^ rd_count;
      rd_count     <= rd_count + 8'h01;
      rd_q.push_back({periph_func, periph_lane});
    end else periph_rdata <= ~periph_rdata;
    if (periph_wr) log_q.push_back({periph_func, periph_lane, periph_wdata});
  end
endmodule : xst_partner

// ==== testbench/xst_engine_tb.sv ====
`timescale 1ns/1ps
`include "xst_regs.svh"

module xst_engine_tb import xst_pkg::*;;
  logic        sys_clk         = 1'b0;
  logic        rst             = 1'b1;
  logic [7:0]  sfr_addr        = 8'h00;
  logic        sfr_wr          = 1'b0;
  logic        sfr_rd          = 1'b0;
  logic [7:0]  sfr_wdata       = 8'h00;
  logic [7:0]  sfr_rdata;
  logic [15:0] ram_addr;
  logic        ram_rd;
  logic        ram_wr;
  logic [7:0]  ram_wdata;
  logic [7:0]  ram_rdata;
  logic [8:0]  periph_ready    = 9'h000;
  logic [3:0]  periph_func;
  logic [1:0]  periph_lane;
  logic        periph_rd;
  logic        periph_wr;
  logic [7:0]  periph_wdata;
  logic [7:0]  periph_rdata;
  logic [6:0]  half_flags;
  logic [6:0]  full_flags;
  logic [7:0]  rd_count;
  logic [31:0] rng_state       = 32'h00000038;
  logic        stall           = 1'b1;
  int          mismatches      = 0;
  int          samples_checked = 0;
  int          moved           = 0;
  int          half_at         = -1;
  int          cur_ch          = 0;
  logic [7:0]  regs [8]        = '{8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hce, 8'hcf, 8'hd6};

  xst_engine uut (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_wr(ram_wr),
    .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .periph_ready(periph_ready), .periph_func(periph_func),
    .periph_lane(periph_lane), .periph_rd(periph_rd), .periph_wr(periph_wr), .periph_wdata(periph_wdata),
    .periph_rdata(periph_rdata), .half_flags(half_flags), .full_flags(full_flags));

  xst_partner prt (.sys_clk(sys_clk), .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_wr(ram_wr),
    .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .periph_func(periph_func), .periph_lane(periph_lane),
    .periph_rd(periph_rd), .periph_wr(periph_wr), .periph_wdata(periph_wdata), .periph_rdata(periph_rdata),
    .rd_count(rd_count));

  always #2.5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    rng_state ^= rng_state << 13;
    rng_state ^= rng_state >> 17;
    rng_state ^= rng_state << 5;
    return rng_state;
  endfunction : xs

  function automatic bit outbound(input logic [3:0] fn);
    return !(fn == `XST_FN_ENC_RAM || fn == `XST_FN_SPI_RAM || fn == `XST_FN_AES_RAM);
  endfunction : outbound

  function automatic logic [7:0] in_byte(input logic [7:0] seq, input int i);
    return 8'h5a ^ (seq + 8'(i));
  endfunction : in_byte

  // Random readiness stalls the engine between bytes
  always @(posedge sys_clk) begin
    #1;
    periph_ready = stall ? 9'h000 : 9'(xs());
  end

  always @(posedge sys_clk) begin
    if (periph_wr || ram_wr) moved++;
    if (half_flags[cur_ch] && half_at < 0) half_at = moved;
  end

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
    end
  endtask : check_byte

  task automatic check_count(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      mismatches++;
      $display("[FAIL] %0t count got %0d expected %0d", $time, got, exp);
    end
  endtask : check_count

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(posedge sys_clk);
    #1;
    sfr_wr = 1'b0;
  endtask : sfr_write

  task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    #1;
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(posedge sys_clk);
    #1;
    sfr_rd = 1'b0;
    check_byte(sfr_rdata, exp);
  endtask : check_reg

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // One channel transfer with all its checks
  // ----------------------------------------------------------------
  task automatic run_xfer(input int ch, input logic [3:0] fn, input logic [7:0] n, input logic cont);
    logic [15:0] base;
    logic [7:0]  seq;
    logic [13:0] ent;
    logic [5:0]  rent;
    base = 16'(xs());
    for (int i = 0; i < n; i++) prt.mem[16'(base + i)] = 8'(xs());
    prt.log_q.delete();
    prt.rd_q.delete();
    seq = rd_count;
    cur_ch = ch;
    sfr_write(`XST_OFS_SEL, 8'(ch));
    sfr_write(`XST_OFS_CFG, {4'h0, fn});
    sfr_write(`XST_OFS_BAL, base[7:0]);
    sfr_write(`XST_OFS_BAH, base[15:8]);
    sfr_write(`XST_OFS_AOL, 8'h00);
    sfr_write(`XST_OFS_AOH, 8'h00);
    sfr_write(`XST_OFS_SZL, n);
    sfr_write(`XST_OFS_SZH, 8'h00);
    sfr_write(`XST_OFS_MD, {7'h00, cont});
    sfr_write(`XST_OFS_FULL, 8'h00);
    sfr_write(`XST_OFS_HALF, 8'h00);
    stall = 1'b1;
    sfr_write(`XST_OFS_EN, 8'h01 << ch);
    check_reg(`XST_OFS_BUSY, 8'h01 << ch);
    moved   = 0;
    half_at = -1;
    stall   = 1'b0;
    for (int k = 0; k < 4000 && !full_flags[ch]; k++) @(posedge sys_clk);
    #1;
    check_byte(sfr_rdata, 8'h01 << ch);
    check_count(moved, n);
    check_count(half_at, n == 1 ? -1 : n >> 1);
    check_byte({1'b0, full_flags}, 8'h01 << ch);
    check_reg(`XST_OFS_HALF, n == 1 ? 8'h00 : 8'h01 << ch);
    check_reg(`XST_OFS_EN, cont ? 8'h01 << ch : 8'h00);
    if (!cont) check_reg(`XST_OFS_AOL, n);
    for (int i = 0; i < n; i++) begin
      if (outbound(fn)) begin
        ent = prt.log_q[i];
        check_byte(ent[7:0], prt.mem[16'(base + i)]);
        check_byte({4'h0, ent[13:10]}, {4'h0, fn});
        check_byte({6'h00, ent[9:8]}, fn == `XST_FN_RAM_ENC ? 8'(i % 3) : 8'h00);
      end else begin
        rent = prt.rd_q[i];
        check_byte(prt.mem[16'(base + i)], in_byte(seq, i));
        check_byte({4'h0, rent[5:2]}, {4'h0, fn});
        check_byte({6'h00, rent[1:0]}, fn == `XST_FN_ENC_RAM ? 8'(i % 3) : 8'h00);
      end
    end
    sfr_write(`XST_OFS_EN, 8'h00);
  endtask : run_xfer

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    for (int a = 8'hc8; a <= 8'hd7; a++) check_reg(8'(a), 8'h00);
    sfr_write(`XST_OFS_BUSY, 8'hff);
    check_reg(`XST_OFS_BUSY, 8'h00);
    sfr_write(8'hd0, 8'h77);
    check_reg(8'hd0, 8'h00);
    for (int ch = 0; ch < 8; ch++) begin
      sfr_write(`XST_OFS_SEL, 8'(ch));
      for (int k = 0; k < 8; k++) sfr_write(regs[k], ch == 7 ? 8'hff : 8'(ch * 16 + k));
    end
    for (int ch = 0; ch < 8; ch++) begin
      sfr_write(`XST_OFS_SEL, 8'(ch));
      for (int k = 0; k < 8; k++) check_reg(regs[k], ch == 7 ? 8'h00 : 8'(ch * 16 + k));
    end
    for (int fn = 0; fn < 9; fn++) run_xfer(fn % 7, 4'(fn), fn == 0 ? 8'h01 : 8'(2 + xs() % 8), 1'b0);
    run_xfer(3, `XST_FN_RAM_ENC, 8'h09, 1'b0);
    run_xfer(6, `XST_FN_RAM_CRC, 8'h03, 1'b1);
    sfr_write(`XST_OFS_SEL, 8'h00);
    sfr_write(`XST_OFS_CFG, 8'h09);
    sfr_write(`XST_OFS_SZL, 8'h02);
    sfr_write(`XST_OFS_AOL, 8'h00);
    sfr_write(`XST_OFS_EN, 8'h01);
    check_reg(`XST_OFS_BUSY, 8'h00);
    tally_and_finish();
  end
endmodule : xst_engine_tb
